// *** inc/sowd_pkg.sv ***
/*
  Constants, field layouts, reset values and encodings for the option-word decoder.
  Assumes 24-bit words whose four low bits carry the word code.
*/
package sowd_pkg;

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CODE_W = 4;
  localparam int EXT_W = 10;
  localparam int LOW_W = 12;
  localparam int FRAC_W = 22;

  // ----------------------------------------------------------------
  // word codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_WORD0 = 4'h0;
  localparam logic [3:0] CODE_PWR = 4'h1;
  localparam logic [3:0] CODE_WORD3 = 4'h3;
  localparam logic [3:0] CODE_WORD4 = 4'h9;
  localparam logic [3:0] CODE_WORD5 = 4'hb;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_AUTO_PU = 23;
  localparam int POS_DITHER = 16;
  localparam int POS_MOD_ORDER = 14;
  localparam int POS_DOUBLER = 12;
  localparam int POS_REF_OUT = 11;
  localparam int POS_AUX_CPP = 10;
  localparam int POS_MAIN_CPP = 9;
  localparam int POS_AUX_PRESC = 8;
  localparam int POS_PIN_FN = 4;
  localparam int POS_EXT_DEN = 14;
  localparam int POS_EXT_NUM = 4;
  localparam int POS_WORD5_ACC = 21;
  localparam int POS_MAIN_PD = 4;
  localparam int POS_AUX_PD = 5;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SI_LATCH = 0;
  localparam int SI_CE = 1;
  localparam int SI_REF = 2;
  localparam int SI_DLM = 3;
  localparam int SI_DLA = 4;
  localparam int SI_ALM = 5;
  localparam int SI_ALA = 6;
  localparam int SI_DIV = 7;
  localparam int NUM_DIV = 4;
  localparam int SI_N = 11;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PF_HIZ = 4'h0, PF_HIGH = 4'h1, PF_LOW = 4'h2, PF_DL_BOTH = 4'h3,
    PF_DL_MAIN = 4'h4, PF_DL_AUX = 4'h5, PF_AL_BOTH_OD = 4'h6, PF_AL_MAIN_OD = 4'h7,
    PF_AL_AUX_OD = 4'h8, PF_AL_BOTH = 4'h9, PF_AL_MAIN = 4'ha, PF_AL_AUX = 4'hb,
    PF_AUX_REF_HALF = 4'hc, PF_AUX_FB_HALF = 4'hd, PF_MAIN_REF_HALF = 4'he,
    PF_MAIN_FB_HALF = 4'hf
  } sowd_pin_fn_t;

  typedef enum logic [1:0] {
    MOD_ORD4 = 2'h0, MOD_OFF = 2'h1, MOD_ORD2 = 2'h2, MOD_ORD3 = 2'h3
  } sowd_mod_t;

  typedef enum logic [1:0] {
    DITHER_SEL_OFF = 2'h0, DITHER_SEL_WEAK = 2'h1, DITHER_SEL_STRONG = 2'h2, DITHER_SEL_RSVD = 2'h3
  } sowd_dither_sel_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_AUTO_PU = 1'b0;
  localparam logic RST_DOUBLER = 1'b0;
  localparam logic RST_REF_OUT = 1'b0;
  localparam logic RST_AUX_CPP = 1'b1;
  localparam logic RST_MAIN_CPP = 1'b1;
  localparam logic RST_AUX_PRESC = 1'b1;
  localparam logic RST_WORD5_ACC = 1'b0;
  localparam logic RST_PD = 1'b0;

endpackage

// *** rtl/sowd_top.sv ***
/*
  Option-word decoder: serial word capture on the link clock, decode and
  application of the option fields on mclk, test/lock pin and reference buffer.
  Assumes the host holds the shift register still while latch is high.
*/
// Operation
// - pin function 0 high impedance, 1 drives high, 2 drives low.
// - codes 3,4,5 drive digital lock: both, main, auxiliary.
// - codes 12-15 drive a divider output halved in frequency.
// - prescaler bit selects 8/9 at 0, 16/17 at 1.
// - main pump polarity negative at 0, positive at 1, default positive.
// - auxiliary pump polarity negative at 0, positive at 1; host normally 1.
// - reference output enable: 0 high impedance, 1 buffered reference copy.
// - doubler on feeds main reference counter twice the reference rate.
// - modulator order 0 fourth, 2 second, 3 third, 1 disabled.
// - dither 0 off, 1 weak, 2 strong, 3 reserved.
// - auto power-up set: word 0 write powers up both loops.
// - that write clears both stored power-down bits.
// - chip enable low suppresses auto power-up.
// - word-5 access set: 22-bit numerator and denominator.
// - word-5 access clear: 12-bit mode, extended bits ignored.
`timescale 1ns/1ps
module sowd_top #(
  parameter int WORD_W = sowd_pkg::WORD_BITS // serial word length
) (
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic link_clk, // serial link clock
  input wire logic link_data, // serial data, msb first
  input wire logic link_latch, // word latch strobe
  input wire logic chip_enable, // chip enable pin
  input wire logic ref_in_pin, // reference input
  input wire logic lock_dig_main, // main digital lock
  input wire logic lock_dig_aux, // aux digital lock
  input wire logic lock_ana_main, // main analog lock
  input wire logic lock_ana_aux, // aux analog lock
  input wire logic [sowd_pkg::NUM_DIV-1:0] div_out, // aux ref, aux fb, main ref, main fb
  input wire logic [sowd_pkg::LOW_W-1:0] frac_num_low, // low numerator bits
  input wire logic [sowd_pkg::LOW_W-1:0] frac_den_low, // low denominator bits
  output logic test_lock_pin_o, // test/lock pin level
  output logic test_lock_pin_oe, // test/lock pin drive
  output logic ref_out_pin_o, // reference out level
  output logic ref_out_pin_oe, // reference out drive
  output logic main_ref_tick, // main ref counter tick
  output logic aux_ref_tick, // aux ref counter tick
  output logic aux_prescaler_16, // 1: 16/17, 0: 8/9
  output logic main_pump_polarity, // 1 positive
  output logic aux_pump_polarity, // 1 positive
  output logic [1:0] modulator_order, // order code
  output logic modulator_en, // modulator active
  output logic [1:0] dither_sel, // dither mode
  output logic main_power_down, // main loop off
  output logic aux_power_down, // aux loop off
  output logic frac_wide, // 22-bit mode
  output logic [sowd_pkg::FRAC_W-1:0] main_frac_numerator, // effective numerator
  output logic [sowd_pkg::FRAC_W-1:0] main_frac_denominator // effective denominator
);
  import sowd_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WORD_W != WORD_BITS) begin : g_bad_width
    $error("sowd_top serves only the fixed word length");
  end

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
  } sowd_link_t;

  sowd_link_t link_r;
  sowd_link_t link_nxt;

  always_comb begin
    link_nxt = link_r;
    link_nxt.shift = {link_r.shift[WORD_BITS-2:0], link_data};
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SI_N-1:0] s1;
    logic [SI_N-1:0] s2;
    logic [SI_N-1:0] s3;
    sowd_pin_fn_t pin_fn;
    logic auto_pu;
    sowd_dither_sel_t dither;
    sowd_mod_t mod_order;
    logic doubler;
    logic ref_out_en;
    logic aux_cpp;
    logic main_cpp;
    logic aux_presc;
    logic wide;
    logic main_pd;
    logic aux_pd;
    logic [EXT_W-1:0] ext_num;
    logic [EXT_W-1:0] ext_den;
    logic [NUM_DIV-1:0] half;
    logic pin_o;
    logic pin_oe;
    logic ref_o;
    logic ref_oe;
    logic main_tick;
    logic aux_tick;
    logic mod_en;
    logic [FRAC_W-1:0] num;
    logic [FRAC_W-1:0] den;
  } sowd_state_t;

  sowd_state_t st_r;
  sowd_state_t st_nxt;

  logic [SI_N-1:0] raw_in;
  assign raw_in = {div_out, lock_ana_aux, lock_ana_main, lock_dig_aux, lock_dig_main,
                   ref_in_pin, chip_enable, link_latch};

  logic latch_rise;
  logic ref_rise;
  logic ref_fall;
  logic [WORD_BITS-1:0] cap_word;
  assign latch_rise = st_r.s2[SI_LATCH] & ~st_r.s3[SI_LATCH];
  assign ref_rise = st_r.s2[SI_REF] & ~st_r.s3[SI_REF];
  assign ref_fall = ~st_r.s2[SI_REF] & st_r.s3[SI_REF];
  // the shift word is stable while latch is high, so it is qualified by the synced latch
  assign cap_word = link_r.shift;

  always_comb begin
    logic ce;
    logic dlm;
    logic dla;
    logic alm;
    logic ala;
    ce = st_r.s2[SI_CE];
    dlm = st_r.s2[SI_DLM];
    dla = st_r.s2[SI_DLA];
    alm = st_r.s2[SI_ALM];
    ala = st_r.s2[SI_ALA];
    st_nxt = st_r;
    st_nxt.s1 = raw_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // ----------------------------------------------------------------
    // word decode
    // ----------------------------------------------------------------
    if (latch_rise) begin
      unique case (cap_word[CODE_W-1:0])
        CODE_WORD0: begin
          if (st_r.auto_pu && ce) begin
            st_nxt.main_pd = 1'b0;
            st_nxt.aux_pd = 1'b0;
          end
        end
        CODE_PWR: begin
          st_nxt.main_pd = cap_word[POS_MAIN_PD];
          st_nxt.aux_pd = cap_word[POS_AUX_PD];
        end
        CODE_WORD3: begin
          st_nxt.wide = cap_word[POS_WORD5_ACC];
        end
        CODE_WORD4: begin
          st_nxt.auto_pu = cap_word[POS_AUTO_PU];
          st_nxt.dither = sowd_dither_sel_t'(cap_word[POS_DITHER+:2]);
          st_nxt.mod_order = sowd_mod_t'(cap_word[POS_MOD_ORDER+:2]);
          st_nxt.doubler = cap_word[POS_DOUBLER];
          st_nxt.ref_out_en = cap_word[POS_REF_OUT];
          st_nxt.aux_cpp = cap_word[POS_AUX_CPP];
          st_nxt.main_cpp = cap_word[POS_MAIN_CPP];
          st_nxt.aux_presc = cap_word[POS_AUX_PRESC];
          st_nxt.pin_fn = sowd_pin_fn_t'(cap_word[POS_PIN_FN+:4]);
        end
        CODE_WORD5: begin
          st_nxt.ext_den = cap_word[POS_EXT_DEN+:EXT_W];
          st_nxt.ext_num = cap_word[POS_EXT_NUM+:EXT_W];
        end
        default: begin
        end
      endcase
    end

    // a reserved dither code is applied as no dither rather than guessed at
    if (st_r.dither == DITHER_SEL_RSVD) begin
      st_nxt.dither = DITHER_SEL_OFF;
    end
    st_nxt.mod_en = (st_r.mod_order != MOD_OFF);

    // ----------------------------------------------------------------
    // fraction width
    // ----------------------------------------------------------------
    if (st_r.wide) begin
      st_nxt.num = {st_r.ext_num, frac_num_low};
      st_nxt.den = {st_r.ext_den, frac_den_low};
    end else begin
      st_nxt.num = {{EXT_W{1'b0}}, frac_num_low};
      st_nxt.den = {{EXT_W{1'b0}}, frac_den_low};
    end

    // ----------------------------------------------------------------
    // divider halving and reference ticks
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_DIV; i++) begin
      if (st_r.s2[SI_DIV+i] && !st_r.s3[SI_DIV+i]) begin
        st_nxt.half[i] = ~st_r.half[i];
      end
    end
    // both edges give twice the rate; the mclk sampling limits the usable reference rate
    st_nxt.main_tick = st_r.doubler ? (ref_rise | ref_fall) : ref_rise;
    st_nxt.aux_tick = ref_rise;
    st_nxt.ref_oe = st_r.ref_out_en;
    st_nxt.ref_o = st_r.ref_out_en & st_r.s2[SI_REF];

    // ----------------------------------------------------------------
    // test/lock pin
    // ----------------------------------------------------------------
    st_nxt.pin_oe = 1'b1;
    st_nxt.pin_o = 1'b0;
    unique case (st_r.pin_fn)
      PF_HIZ: st_nxt.pin_oe = 1'b0;
      PF_HIGH: st_nxt.pin_o = 1'b1;
      PF_LOW: st_nxt.pin_o = 1'b0;
      PF_DL_BOTH: st_nxt.pin_o = dlm & dla;
      PF_DL_MAIN: st_nxt.pin_o = dlm;
      PF_DL_AUX: st_nxt.pin_o = dla;
      // open drain: pull low until locked, then release to the external pull-up
      PF_AL_BOTH_OD: st_nxt.pin_oe = ~(alm & ala);
      PF_AL_MAIN_OD: st_nxt.pin_oe = ~alm;
      PF_AL_AUX_OD: st_nxt.pin_oe = ~ala;
      PF_AL_BOTH: st_nxt.pin_o = alm & ala;
      PF_AL_MAIN: st_nxt.pin_o = alm;
      PF_AL_AUX: st_nxt.pin_o = ala;
      PF_AUX_REF_HALF: st_nxt.pin_o = st_r.half[0];
      PF_AUX_FB_HALF: st_nxt.pin_o = st_r.half[1];
      PF_MAIN_REF_HALF: st_nxt.pin_o = st_r.half[2];
      PF_MAIN_FB_HALF: st_nxt.pin_o = st_r.half[3];
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.pin_fn <= PF_HIZ;
      st_r.auto_pu <= RST_AUTO_PU;
      st_r.dither <= DITHER_SEL_STRONG;
      st_r.mod_order <= MOD_ORD3;
      st_r.doubler <= RST_DOUBLER;
      st_r.ref_out_en <= RST_REF_OUT;
      st_r.aux_cpp <= RST_AUX_CPP;
      st_r.main_cpp <= RST_MAIN_CPP;
      st_r.aux_presc <= RST_AUX_PRESC;
      st_r.wide <= RST_WORD5_ACC;
      st_r.main_pd <= RST_PD;
      st_r.aux_pd <= RST_PD;
      st_r.mod_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign test_lock_pin_o = st_r.pin_o;
  assign test_lock_pin_oe = st_r.pin_oe;
  assign ref_out_pin_o = st_r.ref_o;
  assign ref_out_pin_oe = st_r.ref_oe;
  assign main_ref_tick = st_r.main_tick;
  assign aux_ref_tick = st_r.aux_tick;
  assign aux_prescaler_16 = st_r.aux_presc;
  assign main_pump_polarity = st_r.main_cpp;
  assign aux_pump_polarity = st_r.aux_cpp;
  assign modulator_order = st_r.mod_order;
  assign modulator_en = st_r.mod_en;
  assign dither_sel = st_r.dither;
  assign main_power_down = st_r.main_pd;
  assign aux_power_down = st_r.aux_pd;
  assign frac_wide = st_r.wide;
  assign main_frac_numerator = st_r.num;
  assign main_frac_denominator = st_r.den;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pin_hiz: assert property (st_r.pin_fn == PF_HIZ |=> !test_lock_pin_oe)
    else $error("pin not released in high impedance mode");
  a_pin_high: assert property (st_r.pin_fn == PF_HIGH |=> test_lock_pin_oe && test_lock_pin_o)
    else $error("pin not driven high");
  a_pin_diglock: assert property (st_r.pin_fn == PF_DL_BOTH |=>
      test_lock_pin_oe && (test_lock_pin_o == $past(st_r.s2[SI_DLM] & st_r.s2[SI_DLA])))
    else $error("combined digital lock wrong on pin");
  a_pin_opendrain: assert property ((st_r.pin_fn inside {PF_AL_BOTH_OD, PF_AL_MAIN_OD,
      PF_AL_AUX_OD}) |=> !test_lock_pin_o)
    else $error("open drain pin drove high");
  a_pin_divhalf: assert property ((st_r.pin_fn == PF_MAIN_FB_HALF)
      && $stable(st_r.pin_fn) |=> test_lock_pin_o == $past(st_r.half[3]))
    else $error("halved divider not on pin");
  a_half_toggle: assert property (st_r.s2[SI_DIV+3] && !st_r.s3[SI_DIV+3] |=>
      st_r.half[3] != $past(st_r.half[3]))
    else $error("halving flop missed an edge");
  a_opt_decode: assert property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD4 |=>
      aux_prescaler_16 == $past(cap_word[POS_AUX_PRESC]))
    else $error("prescaler select not taken");
  a_pump_decode: assert property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD4 |=>
      main_pump_polarity == $past(cap_word[POS_MAIN_CPP])
      && aux_pump_polarity == $past(cap_word[POS_AUX_CPP]))
    else $error("pump polarity not taken");
  a_ref_buffer: assert property (st_r.ref_out_en |=> ref_out_pin_oe
      && ref_out_pin_o == $past(st_r.s2[SI_REF]))
    else $error("reference buffer wrong");
  a_ref_hiz: assert property (!st_r.ref_out_en |=> !ref_out_pin_oe)
    else $error("reference pin driven while disabled");
  a_doubler_tick: assert property (st_r.doubler && ref_fall |=> main_ref_tick && !aux_ref_tick)
    else $error("doubled tick missing on falling edge");
  a_mod_off: assert property (st_r.mod_order == MOD_OFF |=> !modulator_en)
    else $error("modulator not disabled");
  a_dither_rsvd: assert property (dither_sel == DITHER_SEL_RSVD |=> dither_sel == DITHER_SEL_OFF)
    else $error("reserved dither code persisted");
  a_auto_pwrup: assert property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD0
      && st_r.auto_pu && st_r.s2[SI_CE] |=> !main_power_down && !aux_power_down)
    else $error("auto power-up did not clear power-down");
  a_ce_block: assert property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD0
      && !st_r.s2[SI_CE] |=> $stable(main_power_down) && $stable(aux_power_down))
    else $error("auto power-up acted with chip enable low");
  a_word5_take: assert property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD5 |=>
      st_r.ext_den == $past(cap_word[POS_EXT_DEN+:EXT_W])
      && st_r.ext_num == $past(cap_word[POS_EXT_NUM+:EXT_W]))
    else $error("extended fraction word not latched");
  a_wide_frac: assert property (st_r.wide |=>
      main_frac_numerator == {$past(st_r.ext_num), $past(frac_num_low)})
    else $error("wide numerator wrong");
  a_narrow_frac: assert property (!st_r.wide |=> main_frac_numerator[FRAC_W-1:LOW_W] == '0
      && main_frac_denominator[FRAC_W-1:LOW_W] == '0)
    else $error("extended bits leaked in narrow mode");

  c_word4: cover property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD4);
  c_auto_pu: cover property (latch_rise && cap_word[CODE_W-1:0] == CODE_WORD0
      && st_r.auto_pu && st_r.s2[SI_CE] && st_r.main_pd);
  c_wide: cover property (st_r.wide && st_r.ext_num != '0);
  c_div_pin: cover property (st_r.pin_fn == PF_MAIN_FB_HALF ##1 $changed(test_lock_pin_o));

endmodule

// *** tb/sowd_host.sv ***
/*
  Host model: shifts 24-bit words msb first on its own 12 ns link clock, then latches.
  Assumes the decoder samples data on the link clock rising edge.
*/
`timescale 1ns/1ps
module sowd_host (
  output logic link_clk, // serial clock, idle low
  output logic link_data, // serial data
  output logic link_latch // word latch
);
  import sowd_pkg::*;
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_latch = 1'b0;
  end
  // clock stands still outside frames; released data shows the inverse of its last bit
  task automatic send_word(input logic [WORD_BITS-1:0] w);
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      link_data = w[i];
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
    link_data = ~w[0];
    #20 link_latch = 1'b1;
    // word held still well past the capture point
    #80 link_latch = 1'b0;
    #40;
  endtask
endmodule

// *** tb/test_synth_option_word_decode.sv ***
/*
  Self-checking bench for the option-word decoder.
  Assumes sowd_host drives the serial link; other inputs change at mclk falling edges.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module test_synth_option_word_decode;
  import sowd_pkg::*;
  logic mclk, rst_b, link_clk, link_data, link_latch, chip_enable, ref_in_pin;
  logic lock_dig_main, lock_dig_aux, lock_ana_main, lock_ana_aux;
  logic [3:0] div_out;
  logic [11:0] frac_num_low, frac_den_low;
  logic test_lock_pin_o, test_lock_pin_oe, ref_out_pin_o, ref_out_pin_oe;
  logic main_ref_tick, aux_ref_tick, aux_prescaler_16, main_pump_polarity;
  logic aux_pump_polarity, modulator_en, main_power_down, aux_power_down, frac_wide;
  logic [1:0] modulator_order, dither_sel, kk;
  logic [21:0] main_frac_numerator, main_frac_denominator;
  logic m, a, ind, ph;
  int err_total, cmp_count, cyc, n_main, n_aux, sel;

  sowd_top #(.WORD_W(24)) u_dut (.mclk, .rst_b, .link_clk, .link_data, .link_latch,
    .chip_enable, .ref_in_pin, .lock_dig_main, .lock_dig_aux, .lock_ana_main,
    .lock_ana_aux, .div_out, .frac_num_low, .frac_den_low, .test_lock_pin_o,
    .test_lock_pin_oe, .ref_out_pin_o, .ref_out_pin_oe, .main_ref_tick, .aux_ref_tick,
    .aux_prescaler_16, .main_pump_polarity, .aux_pump_polarity, .modulator_order,
    .modulator_en, .dither_sel, .main_power_down, .aux_power_down, .frac_wide,
    .main_frac_numerator, .main_frac_denominator);
  sowd_host u_host (.link_clk, .link_data, .link_latch);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard: the whole sequence needs about two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (main_ref_tick === 1'b1) n_main++;
    if (aux_ref_tick === 1'b1) n_aux++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("counts: %0d compares, %0d wrong", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [23:0] w);
    u_host.send_word(w);
    wait_n(2);
  endtask
  function automatic logic [23:0] w4(logic ap, logic [1:0] di, logic [1:0] fm, logic dbl,
    logic ro, logic [2:0] pp, logic [3:0] fn);
    return {ap, 5'h08, di, fm, 1'b0, dbl, ro, pp, fn, CODE_WORD4};
  endfunction

  initial begin
    {rst_b, chip_enable, ref_in_pin, div_out} = 7'h00;
    {lock_dig_main, lock_dig_aux, lock_ana_main, lock_ana_aux} = 4'h0;
    frac_num_low = 12'h123;
    frac_den_low = 12'habc;
    wait_n(3);
    rst_b = 1'b1;
    wait_n(2);
    `CHK({aux_prescaler_16, main_pump_polarity, aux_pump_polarity}, 3'h7)
    `CHK({modulator_order, dither_sel, test_lock_pin_oe, ref_out_pin_oe}, 6'h38)
    $display("test reset done");
    // -----------------------------------------------------------
    // option fields
    // -----------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      wr(w4(1'b0, 2'(i), 2'(i), 1'b0, 1'b0, 3'(i), 4'h0));
      `CHK(modulator_order, 2'(i))
      `CHK(modulator_en, 1'((i % 4) != 1))
      `CHK(dither_sel, (i % 4 == 3) ? 2'h0 : 2'(i))
      `CHK({aux_pump_polarity, main_pump_polarity, aux_prescaler_16}, 3'(i))
    end
    $display("test fields done");
    // -----------------------------------------------------------
    // test/lock pin
    // -----------------------------------------------------------
    for (int c = 0; c < 12; c++) begin
      wr(w4(1'b0, 2'h2, 2'h3, 1'b0, 1'b0, 3'h7, 4'(c)));
      for (int k = 0; k < 4; k++) begin
        kk = 2'(k);
        {lock_dig_main, lock_dig_aux} = kk;
        {lock_ana_main, lock_ana_aux} = ~kk;
        wait_n(6);
        sel = (c - 3) % 3;
        m = (c < 6) ? kk[1] : ~kk[1];
        a = (c < 6) ? kk[0] : ~kk[0];
        ind = (sel == 0) ? (m & a) : (sel == 1) ? m : a;
        if (c < 3) `CHK({test_lock_pin_oe, test_lock_pin_o & (c != 0)}, 2'(c == 1 ? 3 : c))
        else if (c < 6) `CHK({test_lock_pin_oe, test_lock_pin_o}, {1'b1, ind})
        else if (c < 9) `CHK({test_lock_pin_oe, test_lock_pin_o}, {~ind, 1'b0})
        else `CHK({test_lock_pin_oe, test_lock_pin_o}, {1'b1, ind})
      end
    end
    for (int c = 12; c < 16; c++) begin
      wr(w4(1'b0, 2'h2, 2'h3, 1'b0, 1'b0, 3'h7, 4'(c)));
      ph = test_lock_pin_o;
      for (int p = 0; p < 2; p++) begin
        div_out = p ? (4'h1 << (c - 12)) : ~(4'h1 << (c - 12));
        wait_n(3);
        div_out = 4'h0;
        wait_n(4);
        ph = ph ^ 1'(p);
        `CHK({test_lock_pin_oe, test_lock_pin_o}, {1'b1, ph})
      end
    end
    $display("test pin done");
    // -----------------------------------------------------------
    // reference buffer and doubler
    // -----------------------------------------------------------
    for (int r = 0; r < 2; r++) begin
      wr(w4(1'b0, 2'h2, 2'h3, 1'(r), 1'(r), 3'h7, 4'h0));
      n_main = 0;
      n_aux = 0;
      repeat (4) begin
        ref_in_pin = 1'b1;
        wait_n(4);
        `CHK({ref_out_pin_oe, ref_out_pin_o}, {1'(r), 1'(r)})
        ref_in_pin = 1'b0;
        wait_n(4);
        `CHK({ref_out_pin_oe, ref_out_pin_o}, {1'(r), 1'b0})
      end
      wait_n(4);
      `CHK(n_main, r ? 8 : 4)
      `CHK(n_aux, 4)
    end
    $display("test reference done");
    // -----------------------------------------------------------
    // power control and extended fraction
    // -----------------------------------------------------------
    wr({18'h0, 2'b11, CODE_PWR});
    `CHK({main_power_down, aux_power_down}, 2'b11)
    wr({20'h0, CODE_WORD0});
    `CHK({main_power_down, aux_power_down}, 2'b11)
    wr(w4(1'b1, 2'h2, 2'h3, 1'b0, 1'b0, 3'h7, 4'h0));
    chip_enable = 1'b0;
    wait_n(4);
    wr({20'h0, CODE_WORD0});
    `CHK({main_power_down, aux_power_down}, 2'b11)
    chip_enable = 1'b1;
    wait_n(4);
    wr({20'h0, CODE_WORD0});
    `CHK({main_power_down, aux_power_down}, 2'b00)
    wr({10'h2a5, 10'h15a, CODE_WORD5});
    wr({4'b0001, 16'h0, CODE_WORD3});
    `CHK({frac_wide, main_frac_numerator}, {1'b0, 10'h0, 12'h123})
    `CHK(main_frac_denominator, {10'h0, 12'habc})
    wr({4'b0011, 16'h0, CODE_WORD3});
    frac_num_low = 12'h456;
    wait_n(2);
    `CHK({frac_wide, main_frac_numerator}, {1'b1, 10'h15a, 12'h456})
    `CHK(main_frac_denominator, {10'h2a5, 12'habc})
    $display("test power and fraction done");
    wrap_up();
  end
endmodule
